// *** design/cbsp_page_stack.sv ***
`timescale 1ns/100ps
module cbsp_page_stack (
  input wire logic clk_sys,
  input wire logic rst,
  cbsp_pstk_if.stk ps
);
  // hardware push/pop beats a software write in the same cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ps.page <= cbsp_pkg::RST_PAGE; // [R22]
      ps.second <= cbsp_pkg::RST_PAGE; // [R22]
      ps.third <= cbsp_pkg::RST_PAGE;
    end else if (ps.push) begin
      ps.page <= ps.new_page; // [R16]
      ps.second <= ps.page; // [R16]
      ps.third <= ps.second; // [R24]
    end else if (ps.pop) begin
      ps.page <= ps.second; // [R17]
      ps.second <= ps.third; // [R17]
      ps.third <= cbsp_pkg::RST_PAGE; // [R17]
    end else begin
      // plain stores, no push or pop
      if (ps.wr_page) begin
        ps.page <= ps.wdata; // [R18]
      end
      if (ps.wr_second) begin
        ps.second <= ps.wdata; // [R18]
      end
      if (ps.wr_third) begin
        ps.third <= ps.wdata; // [R18]
      end
    end
  end
endmodule : cbsp_page_stack

// *** design/cbsp_pkg.sv ***
package cbsp_pkg;
  // special-function addresses owned by this block
  localparam logic [7:0] SFR_SP = 8'h81;
  localparam logic [7:0] SFR_PAGE = 8'h84;
  localparam logic [7:0] SFR_SECOND = 8'h85;
  localparam logic [7:0] SFR_THIRD = 8'h86;
  localparam logic [7:0] SFR_PGCTL = 8'h96;
  localparam logic [7:0] SFR_BANKSEL = 8'hb1;
  // port registers visible on every page
  localparam logic [7:0] SFR_PORT0 = 8'h80;
  localparam logic [7:0] SFR_PORT1 = 8'h90;
  localparam logic [7:0] SFR_PORT2 = 8'ha0;
  localparam logic [7:0] SFR_PORT3 = 8'hb0;
  // populated pages
  localparam logic [7:0] PAGE_0 = 8'h00;
  localparam logic [7:0] PAGE_3 = 8'h03;
  localparam logic [7:0] PAGE_F = 8'h0f;
  // reset values
  localparam logic [7:0] RST_SP = 8'h07;
  localparam logic [7:0] RST_BANKSEL = 8'h11;
  localparam logic [7:0] RST_PAGE = 8'h00;
  localparam logic RST_AUTO = 1'b1;
  // field layout of the bank-select and page control registers
  localparam logic [7:0] BANKSEL_MASK = 8'h33;
  localparam int CO_LSB = 4;
  localparam int IF_LSB = 0;
  localparam int PGCTL_EN_BIT = 0;
  // program space: address bit 15 marks the banked upper half
  localparam int UPPER_BIT = 15;
  // data space
  localparam int SPLIT_BIT = 7;
  localparam logic [7:0] BIT_BASE = 8'h20;
  localparam int RAM_BYTES = 256;
  // debug stack record depth in bits
  localparam int REC_DEPTH = 32;

  typedef enum logic [1:0] {
    CBSP_TGT_LOW = 2'b00,
    CBSP_TGT_UPPER = 2'b01,
    CBSP_TGT_SFR = 2'b10
  } cbsp_tgt_t;
endpackage : cbsp_pkg

// *** design/cbsp_pstk_if.sv ***
`timescale 1ns/100ps
interface cbsp_pstk_if;
  logic push;
  logic pop;
  logic wr_page;
  logic wr_second;
  logic wr_third;
  logic [7:0] new_page;
  logic [7:0] wdata;
  logic [7:0] page;
  logic [7:0] second;
  logic [7:0] third;
  modport ctrl (output push, pop, wr_page, wr_second, wr_third, new_page, wdata,
    input page, second, third);
  modport stk (input push, pop, wr_page, wr_second, wr_third, new_page, wdata,
    output page, second, third);
endinterface : cbsp_pstk_if

// *** design/cbsp_top.sv ***
`timescale 1ns/100ps
// Functional notes
// [R1] upper-half constant reads go to the bank in the constant-bank field
// [R2] scratchpad constant accesses ignore the constant-bank field
// [R3] upper-half fetches go to the bank in the fetch-bank field
// [R4] fetch-bank field changes only from code running in bank 0
// [R5] program addresses below 0x8000 always map to bank 0
// [R6] 256 bytes of RAM; lower 128 reached directly and indirectly
// [R7] above 0x7f: direct goes to special space, indirect to upper RAM
// [R8] 0x00-0x1f are four register banks picked by status bits 3 and 4
// [R9] bit addresses 0x00-0x7f map onto bytes 0x20-0x2f
// [R10] stack pointer at 0x81; push writes pointer plus one then increments
// [R11] stack pointer resets to 0x07
// [R12] 32-bit record: push/inc one bit in, call two, pop/dec one, return two
// [R13] record overflow and underflow are flagged to debug at speed
// [R14] special registers at addresses ending 0x0 or 0x8 are bit-accessible
// [R15] special space decoded per page byte; pages 0-3 and F exist
// [R16] interrupt entry pushes page stack and loads the interrupting page
// [R17] interrupt return pops page stack; third byte refills with zero
// [R18] software writes to stack bytes never push or pop
// [R19] automatic paging enable resets set, cleared only by software
// [R20] port and paging registers are reachable on every page
// [R21] software must avoid unoccupied special addresses
// [R22] page byte at 0x84 and second byte at 0x85, all pages, reset zero
// [R23] with automatic paging off, entry leaves the current page alone
// [R24] a push overwrites whatever software put in the third byte
// [R25] reserved bank-select bits read zero and ignore writes
module cbsp_top #(
  parameter int REC_W = cbsp_pkg::REC_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [15:0] fetch_addr,
  input wire logic [15:0] const_addr,
  input wire logic const_scratch,
  output logic [16:0] fetch_flash,
  output logic [16:0] const_flash,
  input wire logic [15:0] exec_pc,
  input wire logic [7:0] data_addr,
  input wire logic data_indirect,
  input wire logic data_rd,
  input wire logic data_wr,
  input wire logic [7:0] data_wdata,
  output logic [7:0] data_rdata,
  output logic data_rvalid,
  output cbsp_pkg::cbsp_tgt_t data_target,
  output logic sfr_ext_sel,
  output logic sfr_common,
  output logic sfr_page_ok,
  output logic sfr_bit_ok,
  output logic [7:0] current_page_byte,
  input wire logic [7:0] program_status_word,
  input wire logic [2:0] reg_num,
  output logic [7:0] reg_ram_addr,
  input wire logic [7:0] bit_addr,
  output logic [7:0] bit_byte,
  output logic [2:0] bit_pos,
  output logic bit_in_sfr,
  input wire logic stk_push,
  input wire logic stk_call,
  input wire logic stk_pop,
  input wire logic stk_ret,
  output logic [7:0] stack_pointer,
  output logic [7:0] stk_wr_addr,
  input wire logic int_entry,
  input wire logic [7:0] int_page,
  input wire logic int_return,
  output logic dbg_ovf,
  output logic dbg_unf,
  output logic [REC_W-1:0] dbg_record
);
  localparam int DW = $clog2(REC_W + 1);

  // map a 16-bit program address onto the 17-bit flash
  function automatic logic [16:0] bank_map(input logic [15:0] addr,
                                           input logic [1:0] bank);
    logic [1:0] sel;
    sel = addr[cbsp_pkg::UPPER_BIT] ? bank : 2'h0;
    return {sel, addr[14:0]};
  endfunction : bank_map

  function automatic logic is_addr(input logic [7:0] a, input logic [7:0] b);
    return a == b;
  endfunction : is_addr

  logic [7:0] code_bank_select;
  logic auto_page_enable;
  logic [7:0] ram [cbsp_pkg::RAM_BYTES];
  logic [DW-1:0] rec_depth;
  logic [REC_W-1:0] rec_bits;
  logic [7:0] next_sp;
  logic [DW-1:0] next_depth;
  logic [REC_W-1:0] next_rec;

  cbsp_pstk_if pstk ();

  cbsp_page_stack u_stack (
    .clk_sys(clk_sys),
    .rst(rst),
    .ps(pstk.stk)
  );

  // program space
  wire [1:0] constant_bank_field = code_bank_select[cbsp_pkg::CO_LSB +: 2];
  wire [1:0] fetch_bank_field = code_bank_select[cbsp_pkg::IF_LSB +: 2];
  assign fetch_flash = bank_map(fetch_addr, fetch_bank_field); // [R3] [R5]
  // scratchpad sits outside the banked window
  assign const_flash = const_scratch ? {1'b0, const_addr} // [R2]
                     : bank_map(const_addr, constant_bank_field); // [R1] [R5]
  wire exec_in_bank0 = !exec_pc[cbsp_pkg::UPPER_BIT] || fetch_bank_field == 2'h0; // [R4]

  // data space
  wire above_split = data_addr[cbsp_pkg::SPLIT_BIT];
  assign data_target = !above_split ? cbsp_pkg::CBSP_TGT_LOW // [R6]
                     : data_indirect ? cbsp_pkg::CBSP_TGT_UPPER // [R7]
                     : cbsp_pkg::CBSP_TGT_SFR; // [R7]
  wire tgt_sfr = data_target == cbsp_pkg::CBSP_TGT_SFR;
  wire [7:0] page = pstk.page;
  assign current_page_byte = page;
  wire addr_all_pages = is_addr(data_addr, cbsp_pkg::SFR_PORT0)
                      || is_addr(data_addr, cbsp_pkg::SFR_PORT1)
                      || is_addr(data_addr, cbsp_pkg::SFR_PORT2)
                      || is_addr(data_addr, cbsp_pkg::SFR_PORT3)
                      || is_addr(data_addr, cbsp_pkg::SFR_SP)
                      || is_addr(data_addr, cbsp_pkg::SFR_PAGE)
                      || is_addr(data_addr, cbsp_pkg::SFR_SECOND)
                      || is_addr(data_addr, cbsp_pkg::SFR_THIRD)
                      || is_addr(data_addr, cbsp_pkg::SFR_BANKSEL);
  assign sfr_common = tgt_sfr && addr_all_pages; // [R20] [R22]
  wire page_populated = page <= cbsp_pkg::PAGE_3 || page == cbsp_pkg::PAGE_F;
  assign sfr_page_ok = tgt_sfr && (addr_all_pages || page_populated); // [R15]
  assign sfr_bit_ok = tgt_sfr && data_addr[2:0] == 3'h0; // [R14]
  // page control lives only on page F
  wire hit_pgctl = is_addr(data_addr, cbsp_pkg::SFR_PGCTL) && page == cbsp_pkg::PAGE_F; // [R23]
  wire own_hit = tgt_sfr && (hit_pgctl || (addr_all_pages
               && !is_addr(data_addr, cbsp_pkg::SFR_PORT0)
               && !is_addr(data_addr, cbsp_pkg::SFR_PORT1)
               && !is_addr(data_addr, cbsp_pkg::SFR_PORT2)
               && !is_addr(data_addr, cbsp_pkg::SFR_PORT3)));
  // other special registers belong to peripherals outside
  assign sfr_ext_sel = tgt_sfr && (data_rd || data_wr) && !own_hit; // [R15]
  wire own_wr = data_wr && own_hit;
  wire ram_acc = !tgt_sfr;

  // register banks and bit area
  assign reg_ram_addr = {3'h0, program_status_word[4:3], reg_num}; // [R8]
  assign bit_in_sfr = bit_addr[7];
  assign bit_byte = bit_addr[7] ? {bit_addr[7:3], 3'h0} // [R14]
                  : cbsp_pkg::BIT_BASE + {4'h0, bit_addr[6:3]}; // [R9]
  assign bit_pos = bit_addr[2:0]; // [R9]

  // bank select register
  wire wr_banksel = own_wr && is_addr(data_addr, cbsp_pkg::SFR_BANKSEL);
  wire [7:0] keep_mask = exec_in_bank0 ? 8'h00 : 8'h03;
  wire [7:0] banksel_new = ((data_wdata & ~keep_mask) | (code_bank_select & keep_mask))
                         & cbsp_pkg::BANKSEL_MASK; // [R4] [R25]
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      code_bank_select <= cbsp_pkg::RST_BANKSEL;
    end else if (wr_banksel) begin
      code_bank_select <= banksel_new;
    end
  end

  // automatic paging enable
  wire wr_pgctl = own_wr && hit_pgctl;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      auto_page_enable <= cbsp_pkg::RST_AUTO; // [R19]
    end else if (wr_pgctl) begin
      auto_page_enable <= data_wdata[cbsp_pkg::PGCTL_EN_BIT]; // [R19]
    end
  end

  // page stack control; with paging off interrupts neither push nor pop the stack
  assign pstk.push = int_entry && auto_page_enable; // [R16] [R23]
  assign pstk.pop = int_return && auto_page_enable; // [R17]
  assign pstk.new_page = int_page;
  assign pstk.wdata = data_wdata;
  assign pstk.wr_page = own_wr && is_addr(data_addr, cbsp_pkg::SFR_PAGE); // [R18]
  assign pstk.wr_second = own_wr && is_addr(data_addr, cbsp_pkg::SFR_SECOND); // [R18]
  assign pstk.wr_third = own_wr && is_addr(data_addr, cbsp_pkg::SFR_THIRD); // [R18]

  // stack pointer
  wire wr_sp = own_wr && is_addr(data_addr, cbsp_pkg::SFR_SP);
  wire sp_inc = wr_sp && data_wdata == 8'(stack_pointer + 8'h01);
  wire sp_dec = wr_sp && data_wdata == 8'(stack_pointer - 8'h01);
  assign stk_wr_addr = 8'(stack_pointer + 8'h01); // [R10]
  always_comb begin
    next_sp = stack_pointer;
    if (stk_call) begin
      next_sp = 8'(stack_pointer + 8'h02);
    end else if (stk_push) begin
      next_sp = 8'(stack_pointer + 8'h01); // [R10]
    end else if (stk_ret) begin
      next_sp = 8'(stack_pointer - 8'h02);
    end else if (stk_pop) begin
      next_sp = 8'(stack_pointer - 8'h01);
    end else if (wr_sp) begin
      next_sp = data_wdata;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stack_pointer <= cbsp_pkg::RST_SP; // [R11]
    end else begin
      stack_pointer <= next_sp;
    end
  end

  // debug stack record; bits shifted out past the top are lost
  wire [1:0] rec_in = stk_call ? 2'h2 : (stk_push || sp_inc) ? 2'h1 : 2'h0; // [R12]
  wire [1:0] rec_out = (rec_in != 2'h0) ? 2'h0
                     : stk_ret ? 2'h2 : (stk_pop || sp_dec) ? 2'h1 : 2'h0; // [R12]
  wire [DW:0] depth_sum = {1'b0, rec_depth} + (DW+1)'(rec_in);
  wire rec_ovf = rec_in != 2'h0 && depth_sum > (DW+1)'(REC_W); // [R13]
  wire rec_unf = rec_out != 2'h0 && rec_depth < DW'(rec_out); // [R13]
  always_comb begin
    next_depth = rec_depth;
    next_rec = rec_bits;
    if (rec_in == 2'h2) begin
      next_rec = {rec_bits[REC_W-3:0], 2'h3};
    end else if (rec_in == 2'h1) begin
      next_rec = {rec_bits[REC_W-2:0], 1'b0};
    end else if (rec_out == 2'h2) begin
      next_rec = {2'h0, rec_bits[REC_W-1:2]};
    end else if (rec_out == 2'h1) begin
      next_rec = {1'b0, rec_bits[REC_W-1:1]};
    end
    if (rec_ovf) begin
      next_depth = DW'(REC_W);
    end else if (rec_unf) begin
      next_depth = '0;
    end else if (rec_in != 2'h0) begin
      next_depth = depth_sum[DW-1:0];
    end else begin
      next_depth = DW'(rec_depth - DW'(rec_out));
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rec_depth <= '0;
      rec_bits <= '0;
      dbg_ovf <= 1'b0;
      dbg_unf <= 1'b0;
    end else begin
      rec_depth <= next_depth;
      rec_bits <= next_rec;
      dbg_ovf <= rec_ovf; // [R13]
      dbg_unf <= rec_unf; // [R13]
    end
  end
  assign dbg_record = rec_bits;

  // data RAM: one flat array; the upper half only through indirect access
  always_ff @(posedge clk_sys) begin
    if (data_wr && ram_acc) begin
      ram[data_addr] <= data_wdata; // [R6] [R7]
    end
  end

  // read answer one cycle after the request
  wire [7:0] own_rdata =
      is_addr(data_addr, cbsp_pkg::SFR_SP) ? stack_pointer
    : is_addr(data_addr, cbsp_pkg::SFR_PAGE) ? pstk.page
    : is_addr(data_addr, cbsp_pkg::SFR_SECOND) ? pstk.second
    : is_addr(data_addr, cbsp_pkg::SFR_THIRD) ? pstk.third
    : is_addr(data_addr, cbsp_pkg::SFR_BANKSEL) ? (code_bank_select & cbsp_pkg::BANKSEL_MASK)
    : {7'h0, auto_page_enable};
  wire rd_take = data_rd && (ram_acc || own_hit);
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      data_rdata <= 8'h00;
      data_rvalid <= 1'b0;
    end else begin
      data_rvalid <= rd_take;
      if (rd_take) begin
        data_rdata <= ram_acc ? ram[data_addr] : own_rdata;
      end
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence s_enter;
    int_entry && auto_page_enable;
  endsequence
  sequence s_leave;
    int_return && auto_page_enable && !int_entry;
  endsequence

  a_sp_reset_val: assert property ($fell(rst) |-> stack_pointer == cbsp_pkg::RST_SP) // [R11]
    else $error("stack pointer not 0x07 after reset");
  a_sp_push_step: assert property (stk_push && !stk_call |=>
    stack_pointer == 8'($past(stack_pointer) + 8'h01)) // [R10]
    else $error("push did not step pointer by one");
  a_low_half_bank0: assert property (!fetch_addr[15] |-> fetch_flash[16:15] == 2'h0) // [R5]
    else $error("lower program half not in bank 0");
  a_fetch_bank_map: assert property (fetch_addr[15] |->
    fetch_flash[16:15] == code_bank_select[1:0]) // [R3]
    else $error("upper fetch took wrong bank");
  a_fetch_bank_guard: assert property (wr_banksel && !exec_in_bank0 |=>
    code_bank_select[1:0] == $past(code_bank_select[1:0])) // [R4]
    else $error("fetch bank changed from outside bank 0");
  a_page_push: assert property (s_enter |=> pstk.page == $past(int_page)
    && pstk.second == $past(pstk.page) && pstk.third == $past(pstk.second)) // [R16]
    else $error("page stack push wrong");
  a_page_pop: assert property (s_leave |=> pstk.page == $past(pstk.second)
    && pstk.second == $past(pstk.third) && pstk.third == 8'h00) // [R17]
    else $error("page stack pop wrong");
  a_auto_off_hold: assert property (int_entry && !auto_page_enable && !pstk.wr_page |=>
    pstk.page == $past(pstk.page)) // [R23]
    else $error("page changed with automatic paging off");
  a_direct_upper: assert property (data_addr[7] && !data_indirect |->
    data_target == cbsp_pkg::CBSP_TGT_SFR && !ram_acc) // [R7]
    else $error("direct access above 0x7f not sent to special space");
  a_rsv_bits_zero: assert property ((code_bank_select & ~cbsp_pkg::BANKSEL_MASK) == 8'h00) // [R25]
    else $error("reserved bank-select bits set");
  a_rec_overflow: assert property (rec_depth == DW'(REC_W) && stk_push && !stk_call |=>
    dbg_ovf && rec_depth == DW'(REC_W)) // [R13]
    else $error("record overflow not flagged");
endmodule : cbsp_top

// *** sim/cbsp_core_model.sv ***
`timescale 1ns/100ps
module cbsp_core_model (
  input wire logic clk_sys,
  input wire logic [7:0] data_rdata,
  input wire logic data_rvalid,
  output logic [15:0] exec_pc,
  output logic [7:0] data_addr,
  output logic data_indirect,
  output logic data_rd,
  output logic data_wr,
  output logic [7:0] data_wdata,
  output logic [5:0] evt,
  output logic [7:0] int_page
);
  initial begin
    exec_pc = 16'h0000;
    data_addr = 8'h00;
    data_indirect = 1'b0;
    data_rd = 1'b0;
    data_wr = 1'b0;
    data_wdata = 8'h00;
    evt = 6'h00;
    int_page = 8'h00;
  end
  // callers of rd and wr keep to occupied special addresses only
  task automatic aim(input logic [7:0] a, input logic ind);
    @(posedge clk_sys);
    data_addr <= a;
    data_indirect <= ind;
  endtask : aim
  task automatic wr(input logic [7:0] a, input logic ind, input logic [7:0] d,
      input logic [15:0] pc);
    aim(a, ind);
    data_wdata <= d;
    exec_pc <= pc;
    data_wr <= 1'b1;
    @(posedge clk_sys);
    data_wr <= 1'b0;
    // stale data inverted so a late sample cannot pass
    data_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic ind, output logic [8:0] q);
    aim(a, ind);
    data_rd <= 1'b1;
    @(posedge clk_sys);
    data_rd <= 1'b0;
    @(posedge clk_sys);
    q = {data_rvalid, data_rdata};
  endtask : rd
  // bits: push, call, pop, ret, int entry, int return
  task automatic ev(input logic [5:0] v, input logic [7:0] pg);
    @(posedge clk_sys);
    evt <= v;
    int_page <= pg;
    @(posedge clk_sys);
    evt <= 6'h00;
    int_page <= ~pg;
  endtask : ev
endmodule : cbsp_core_model

// *** sim/code_bank_sfr_page_stack_tb.sv ***
`timescale 1ns/100ps
module code_bank_sfr_page_stack_tb;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [15:0] fetch_addr = 16'h0000;
  logic [15:0] const_addr = 16'h0000;
  logic const_scratch = 1'b0;
  logic [7:0] program_status_word = 8'h00;
  logic [2:0] reg_num = 3'h0;
  logic [7:0] bit_addr = 8'h00;
  logic [16:0] fetch_flash, const_flash;
  logic [15:0] exec_pc;
  logic [7:0] data_addr, data_wdata, data_rdata, current_page_byte, reg_ram_addr, bit_byte;
  logic [7:0] stack_pointer, stk_wr_addr, int_page;
  logic data_indirect, data_rd, data_wr, data_rvalid, sfr_ext_sel, sfr_common;
  logic sfr_page_ok, sfr_bit_ok, bit_in_sfr, dbg_ovf, dbg_unf;
  logic [2:0] bit_pos;
  logic [5:0] evt;
  logic [31:0] dbg_record;
  cbsp_pkg::cbsp_tgt_t data_target;
  int failures = 0;
  int checked = 0;
  integer seed = 44;
  logic [31:0] r;
  logic [7:0] v;
  logic [5:0] ops [4] = '{6'h02, 6'h01, 6'h04, 6'h08};
  logic [7:0] sps [4] = '{8'h09, 8'h0a, 8'h09, 8'h07};
  logic [7:0] recs [4] = '{8'h03, 8'h06, 8'h03, 8'h00};

  cbsp_top cbsp_top_i (.clk_sys, .rst, .fetch_addr, .const_addr, .const_scratch, .fetch_flash,
    .const_flash, .exec_pc, .data_addr, .data_indirect, .data_rd, .data_wr, .data_wdata,
    .data_rdata, .data_rvalid, .data_target, .sfr_ext_sel, .sfr_common, .sfr_page_ok,
    .sfr_bit_ok, .current_page_byte, .program_status_word, .reg_num, .reg_ram_addr, .bit_addr,
    .bit_byte, .bit_pos, .bit_in_sfr, .stk_push(evt[0]), .stk_call(evt[1]), .stk_pop(evt[2]),
    .stk_ret(evt[3]), .stack_pointer, .stk_wr_addr, .int_entry(evt[4]), .int_page,
    .int_return(evt[5]), .dbg_ovf, .dbg_unf, .dbg_record);
  cbsp_core_model cbsp_core_model_i (.clk_sys, .data_rdata, .data_rvalid, .exec_pc, .data_addr,
    .data_indirect, .data_rd, .data_wr, .data_wdata, .evt, .int_page);

  always #25 clk_sys = ~clk_sys;

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done
  task automatic do_reset;
    rst <= 1'b1;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
  endtask : do_reset
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    cbsp_core_model_i.wr(a, 1'b0, d, 16'h0100);
  endtask : w
  task automatic rc(input string nm, input logic [7:0] a, input logic ind, input logic [8:0] e);
    logic [8:0] q;
    cbsp_core_model_i.rd(a, ind, q);
    chk(nm, q, e);
  endtask : rc
  task automatic ev(input logic [5:0] c, input logic [7:0] pg);
    cbsp_core_model_i.ev(c, pg);
    #1;
  endtask : ev
  function automatic logic [16:0] map(input logic [15:0] a, input logic [1:0] b);
    return a[15] ? {b, a[14:0]} : {2'b00, a[14:0]};
  endfunction : map
  function automatic logic [7:0] bbyte(input logic [7:0] b);
    return b[7] ? (b & 8'hf8) : (8'h20 + {4'h0, b[6:3]});
  endfunction : bbyte
  function automatic logic [1:0] tgt(input logic [7:0] a, input logic ind);
    return !a[7] ? 2'b00 : (ind ? 2'b01 : 2'b10);
  endfunction : tgt

  // generous: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    $display("watchdog expired");
    test_done();
  end

  initial begin
    do_reset();
    chk("sp", stack_pointer, 8'h07);
    chk("push addr", stk_wr_addr, 8'h08);
    chk("page", current_page_byte, 8'h00);
    rc("banksel", cbsp_pkg::SFR_BANKSEL, 1'b0, 9'h111);
    rc("second", cbsp_pkg::SFR_SECOND, 1'b0, 9'h100);
    w(cbsp_pkg::SFR_PAGE, 8'h0f);
    rc("auto en", cbsp_pkg::SFR_PGCTL, 1'b0, 9'h101);
    $display("test reset done");
    for (int i = 0; i < 12; i++) begin
      v = $random(seed);
      w(cbsp_pkg::SFR_BANKSEL, v);
      rc("banksel", cbsp_pkg::SFR_BANKSEL, 1'b0, {1'b1, v & 8'h33});
      repeat (4) begin
        r = $random(seed);
        @(posedge clk_sys);
        fetch_addr <= r[15:0];
        const_addr <= r[31:16];
        const_scratch <= r[3];
        #1;
        chk("fetch", fetch_flash, map(r[15:0], v[1:0]));
        chk("const", const_flash, r[3] ? {1'b0, r[31:16]} : map(r[31:16], v[5:4]));
      end
    end
    w(cbsp_pkg::SFR_BANKSEL, 8'h01);
    cbsp_core_model_i.wr(cbsp_pkg::SFR_BANKSEL, 1'b0, 8'h32, 16'h9000);
    rc("banked write", cbsp_pkg::SFR_BANKSEL, 1'b0, 9'h131);
    $display("test banks done");
    for (int i = 0; i < 40; i++) begin
      r = $random(seed);
      cbsp_core_model_i.aim(r[7:0], r[8]);
      program_status_word <= r[23:16];
      reg_num <= r[11:9];
      bit_addr <= r[31:24];
      #1;
      chk("target", data_target, tgt(r[7:0], r[8]));
      if (tgt(r[7:0], r[8]) == 2'b10) chk("bit ok", sfr_bit_ok, r[2:0] == 3'h0);
      chk("reg addr", reg_ram_addr, {3'h0, r[20:19], r[11:9]});
      chk("bit byte", bit_byte, bbyte(r[31:24]));
      chk("bit pos", {bit_in_sfr, bit_pos}, {r[31], r[26:24]});
    end
    cbsp_core_model_i.wr(8'h90, 1'b1, 8'h5a, 16'h0100);
    w(8'h10, 8'ha5);
    rc("upper ram", 8'h90, 1'b1, 9'h15a);
    rc("lower ram", 8'h10, 1'b1, 9'h1a5);
    w(cbsp_pkg::SFR_PAGE, 8'h05);
    cbsp_core_model_i.aim(8'h99, 1'b0);
    #1;
    chk("page ok", sfr_page_ok, 1'b0);
    cbsp_core_model_i.aim(cbsp_pkg::SFR_PORT0, 1'b0);
    #1;
    chk("common", {sfr_common, sfr_page_ok}, 2'b11);
    w(cbsp_pkg::SFR_PAGE, 8'h03);
    cbsp_core_model_i.aim(8'h99, 1'b0);
    #1;
    chk("page ok", sfr_page_ok, 1'b1);
    // read of a register held outside: no answer here, old data stays
    fork
      rc("ext read", 8'h99, 1'b0, 9'h0a5);
      begin
        @(posedge clk_sys);
        #1;
        chk("ext sel", sfr_ext_sel, 1'b1);
      end
    join
    $display("test decode done");
    for (int i = 0; i < 4; i++) begin
      ev(ops[i], 8'h00);
      chk("sp", stack_pointer, sps[i]);
      chk("push addr", stk_wr_addr, sps[i] + 8'h01);
      chk("record", dbg_record[7:0], recs[i]);
    end
    // pointer writes of plus or minus one count as increment and decrement
    ev(6'h02, 8'h00);
    w(cbsp_pkg::SFR_SP, 8'h0a);
    #1;
    chk("record", dbg_record[7:0], 8'h06);
    w(cbsp_pkg::SFR_SP, 8'h09);
    #1;
    chk("record", dbg_record[7:0], 8'h03);
    ev(6'h08, 8'h00);
    chk("sp", stack_pointer, 8'h07);
    chk("record", dbg_record[7:0], 8'h00);
    ev(6'h04, 8'h00);
    chk("underflow", dbg_unf, 1'b1);
    for (int i = 0; i < 33; i++) begin
      ev(6'h01, 8'h00);
      chk("overflow", dbg_ovf, i == 32);
    end
    $display("test stack done");
    do_reset();
    w(cbsp_pkg::SFR_THIRD, 8'h44);
    chk("page", current_page_byte, 8'h00);
    rc("third", cbsp_pkg::SFR_THIRD, 1'b0, 9'h144);
    w(cbsp_pkg::SFR_PAGE, 8'h0f);
    ev(6'h10, 8'h02);
    chk("page", current_page_byte, 8'h02);
    rc("third", cbsp_pkg::SFR_THIRD, 1'b0, 9'h100);
    ev(6'h10, 8'h00);
    chk("page", current_page_byte, 8'h00);
    rc("second", cbsp_pkg::SFR_SECOND, 1'b0, 9'h102);
    rc("third", cbsp_pkg::SFR_THIRD, 1'b0, 9'h10f);
    ev(6'h20, 8'h00);
    chk("page", current_page_byte, 8'h02);
    rc("third", cbsp_pkg::SFR_THIRD, 1'b0, 9'h100);
    ev(6'h20, 8'h00);
    chk("page", current_page_byte, 8'h0f);
    rc("second", cbsp_pkg::SFR_SECOND, 1'b0, 9'h100);
    w(cbsp_pkg::SFR_PGCTL, 8'h00);
    ev(6'h10, 8'h01);
    chk("page", current_page_byte, 8'h0f);
    rc("auto en", cbsp_pkg::SFR_PGCTL, 1'b0, 9'h100);
    $display("test paging done");
    test_done();
  end
endmodule : code_bank_sfr_page_stack_tb
